// file: ccu_calendar_clock_unit.sv
// Calendar clock unit: BCD time and calendar, AXI4-Lite registers, interrupt.
// Assumes xtal_clk is a free 32.768 kHz level, sampled into clk_sys by two flops.
`timescale 1ns/100ps

// Behaviour
// - Hours counted 00 to 23, no AM/PM
// - Calendar spans 2000-01-01 to 2099-12-31
// - February gets 29 days in leap years
// - One second steps; half-second phase readable
// - All values held as BCD digits
// - Time base from 32.768 kHz crystal
// - Output pin: alarm pulse or seconds clock
// - Calibration corrects up to 128 crystal ticks per minute
// - Day: tens bits 5-4, ones bits 3-0
// - Weekday: bits 2-0, values 0 to 6
// - Hours: tens bits 5-4, ones bits 3-0
// - Minutes: tens bits 6-4, ones bits 3-0
// - Seconds: tens bits 6-4, ones bits 3-0
// - Day, weekday, hour writes need unlock bit
// - Unimplemented upper bits read as zero
module ccu_calendar_clock_unit #(
    parameter int HALF_TICKS = ccu_pkg::HALF_SECOND_TICKS
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic xtal_clk,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq,
    output logic clock_out_pin
);
    import ccu_pkg::*;

    if (HALF_TICKS < 2 || HALF_TICKS > 65535) begin : g_check
        $error("HALF_TICKS out of range");
    end

    // ****************************************************************
    // Crystal synchroniser and edge detect
    // ****************************************************************
    logic xtal_meta;
    logic xtal_sync;
    logic xtal_prev;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            xtal_meta <= 1'b0;
            xtal_sync <= 1'b0;
            xtal_prev <= 1'b0;
        end else begin
            xtal_meta <= xtal_clk;
            xtal_sync <= xtal_meta;
            xtal_prev <= xtal_sync;
        end
    end
    wire xtal_rise = xtal_sync & ~xtal_prev;

    // ****************************************************************
    // Control registers
    // ****************************************************************
    logic [7:0] control;
    logic [7:0] calibration;
    logic [IRQ_WIDTH-1:0] irq_status;
    logic [IRQ_WIDTH-1:0] irq_mask;
    logic [7:0] alarm_second;
    ccu_time_t tm;

    wire run_en = control[CTRL_ENABLE_BIT];
    wire unlock = control[CTRL_UNLOCK_BIT];

    // ****************************************************************
    // Half-second prescaler with calibration
    // ****************************************************************
    logic [15:0] prescale;
    logic half_phase;
    logic [5:0] cal_secs;
    wire signed [7:0] cal_signed = signed'(calibration);
    wire cal_slot = (cal_secs == 6'(CAL_INTERVAL_SECONDS - 1)) && half_phase;
    // Once per minute the last half period is stretched or shortened by the calibration value
    wire [15:0] half_limit = cal_slot ? 16'(HALF_TICKS - 1 - 32'(cal_signed)) : 16'(HALF_TICKS - 1);
    wire half_tick = run_en && xtal_rise && (prescale >= half_limit);
    wire sec_tick = half_tick && half_phase;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prescale <= 16'h0000;
            half_phase <= 1'b0;
            cal_secs <= 6'h00;
        end else if (run_en && xtal_rise) begin
            prescale <= half_tick ? 16'h0000 : prescale + 16'h0001;
            half_phase <= half_tick ? ~half_phase : half_phase;
            if (sec_tick) begin
                cal_secs <= (cal_secs == 6'(CAL_INTERVAL_SECONDS - 1)) ? 6'h00 : cal_secs + 6'h01;
            end
        end
    end

    // ****************************************************************
    // BCD counting
    // ****************************************************************
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction

    // Leap year: every year divisible by four in 2000-2099, 2000 included
    wire [3:0] yr_ones = tm.year[3:0];
    wire leap = tm.year[4] ? (yr_ones == 4'h2 || yr_ones == 4'h6) : (yr_ones == 4'h0 || yr_ones == 4'h4 || yr_ones == 4'h8);
    logic [7:0] month_last;
    always_comb begin
        case (tm.month)
            8'h02: month_last = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
            default: month_last = 8'h31;
        endcase
    end

    wire sec_wrap = sec_tick && (tm.second == 8'h59);
    wire min_wrap = sec_wrap && (tm.minute == 8'h59);
    wire hour_wrap = min_wrap && (tm.hour == 8'h23);
    wire day_wrap = hour_wrap && (tm.day == month_last);
    wire month_wrap = day_wrap && (tm.month == 8'h12);

    ccu_time_t next_tm;
    always_comb begin
        next_tm = tm;
        if (sec_tick) begin
            next_tm.second = sec_wrap ? 8'h00 : bcd_inc(tm.second);
        end
        if (sec_wrap) begin
            next_tm.minute = min_wrap ? 8'h00 : bcd_inc(tm.minute);
        end
        if (min_wrap) begin
            next_tm.hour = hour_wrap ? 8'h00 : bcd_inc(tm.hour);
        end
        if (hour_wrap) begin
            next_tm.weekday = (tm.weekday == 8'h06) ? 8'h00 : tm.weekday + 8'h01;
            next_tm.day = day_wrap ? 8'h01 : bcd_inc(tm.day);
        end
        if (day_wrap) begin
            next_tm.month = month_wrap ? 8'h01 : bcd_inc(tm.month);
        end
        if (month_wrap) begin
            next_tm.year = (tm.year == 8'h99) ? 8'h00 : bcd_inc(tm.year);
        end
    end

    // ****************************************************************
    // AXI4-Lite write channel
    // ****************************************************************
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire have_aw = aw_held || aw_take;
    wire have_w = w_held || w_take;
    wire wr_fire = have_aw && have_w && !s_axi_bvalid;
    wire [7:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
    wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
    wire wr_lane0 = w_held ? w_strb[0] : s_axi_wstrb[0];
    wire [7:0] wb = wr_data[7:0];
    wire wr_ok = wr_fire && wr_lane0;

    wire wr_sec = wr_ok && wr_addr == ADDR_SECOND_VALUE;
    wire wr_min = wr_ok && wr_addr == ADDR_MINUTE_VALUE;
    wire wr_hour = wr_ok && wr_addr == ADDR_HOUR_VALUE && unlock;
    wire wr_weekday_value = wr_ok && wr_addr == ADDR_WEEKDAY_VALUE && unlock;
    wire wr_day = wr_ok && wr_addr == ADDR_DAY_OF_MONTH_VALUE && unlock;
    wire wr_mon = wr_ok && wr_addr == ADDR_MONTH_VALUE;
    wire wr_year = wr_ok && wr_addr == ADDR_YEAR_VALUE;
    wire wr_ctrl = wr_ok && wr_addr == ADDR_CONTROL;
    wire wr_mask = wr_ok && wr_addr == ADDR_IRQ_MASK;
    wire wr_cal = wr_ok && wr_addr == ADDR_CALIBRATION;
    wire wr_alarm = wr_ok && wr_addr == ADDR_STATUS;
    wire wr_known = (wr_addr <= ADDR_CALIBRATION) && (wr_addr[1:0] == 2'b00);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (aw_take && !wr_fire) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (w_take && !wr_fire) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Time, control and interrupt registers
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tm <= '{ZERO_RESET, ZERO_RESET, ZERO_RESET, ZERO_RESET, DAY_RESET, MONTH_RESET, ZERO_RESET};
            control <= CTRL_RESET;
            calibration <= 8'h00;
            irq_mask <= '0;
            alarm_second <= 8'h00;
        end else begin
            tm <= next_tm;
            // Software writes win over a tick in the same cycle
            if (wr_sec) tm.second <= wb & SECOND_MASK;
            if (wr_min) tm.minute <= wb & MINUTE_MASK;
            if (wr_hour) tm.hour <= wb & HOUR_MASK;
            if (wr_weekday_value) tm.weekday <= wb & WEEKDAY_MASK;
            if (wr_day) tm.day <= wb & DAY_MASK;
            if (wr_mon) tm.month <= wb & MONTH_MASK;
            if (wr_year) tm.year <= wb;
            if (wr_ctrl) control <= wb & 8'h0F;
            if (wr_cal) calibration <= wb;
            if (wr_mask) irq_mask <= wb[IRQ_WIDTH-1:0];
            if (wr_alarm) alarm_second <= wb & SECOND_MASK;
        end
    end

    // ****************************************************************
    // AXI4-Lite read channel
    // ****************************************************************
    wire rd_take = s_axi_arvalid && s_axi_arready;
    assign s_axi_arready = !s_axi_rvalid;
    wire rd_irq_status = rd_take && s_axi_araddr == ADDR_IRQ_STATUS;
    logic [7:0] rd_byte;
    logic rd_known;
    always_comb begin
        rd_known = 1'b1;
        case (s_axi_araddr)
            ADDR_SECOND_VALUE: rd_byte = tm.second & SECOND_MASK;
            ADDR_MINUTE_VALUE: rd_byte = tm.minute & MINUTE_MASK;
            ADDR_HOUR_VALUE: rd_byte = tm.hour & HOUR_MASK;
            ADDR_WEEKDAY_VALUE: rd_byte = tm.weekday & WEEKDAY_MASK;
            ADDR_DAY_OF_MONTH_VALUE: rd_byte = tm.day & DAY_MASK;
            ADDR_MONTH_VALUE: rd_byte = tm.month & MONTH_MASK;
            ADDR_YEAR_VALUE: rd_byte = tm.year;
            ADDR_CONTROL: rd_byte = control;
            ADDR_STATUS: rd_byte = {alarm_second[6:0], half_phase};
            ADDR_IRQ_STATUS: rd_byte = {4'h0, irq_status};
            ADDR_IRQ_MASK: rd_byte = {4'h0, irq_mask};
            ADDR_CALIBRATION: rd_byte = calibration;
            default: begin
                rd_byte = 8'h00;
                rd_known = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // Interrupts: sticky, cleared by read, set wins over clear
    // ****************************************************************
    wire [IRQ_WIDTH-1:0] irq_event = {hour_wrap, min_wrap, half_tick, sec_tick};
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irq_status <= '0;
            irq <= 1'b0;
        end else begin
            irq_status <= (rd_irq_status ? '0 : irq_status) | irq_event;
            irq <= |(irq_status & irq_mask);
        end
    end

    // ****************************************************************
    // Output pin: alarm pulse or seconds clock
    // ****************************************************************
    wire alarm_hit = sec_tick && (next_tm.second == alarm_second);
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            clock_out_pin <= 1'b0;
        end else if (!control[CTRL_OUT_EN_BIT]) begin
            clock_out_pin <= 1'b0;
        end else if (control[CTRL_OUT_SEL_BIT]) begin
            clock_out_pin <= half_phase;
        end else begin
            clock_out_pin <= alarm_hit;
        end
    end

endmodule

// file: ccu_monitor.sv
// Checker for the calendar clock unit: register bus handshakes and value field ranges.
// Assumes it is bound to ccu_calendar_clock_unit and sees only its ports.
`timescale 1ns/100ps
module ccu_monitor
    import ccu_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    logic [7:0] rd_addr;
    wire rd_unmapped = rd_addr > ADDR_CALIBRATION || |rd_addr[1:0];
    wire [7:0] rb = s_axi_rdata[7:0];
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) rd_addr <= 8'h00;
        else if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr;
    end
    // ****************************************************************
    // Handshakes
    // ****************************************************************
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");
    a_read_stand: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
        && $stable(s_axi_rresp)) else $error("read answer dropped");
    a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write not answered");
    a_write_stand: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
    a_unmapped_read: assert property (s_axi_rvalid |-> (s_axi_rresp == RESP_SLVERR) == rd_unmapped
        && (!rd_unmapped || s_axi_rdata == 32'h0000_0000)) else $error("bad read response");
    // ****************************************************************
    // Value fields
    // ****************************************************************
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000) else $error("upper bits set");
    a_second_bcd: assert property (s_axi_rvalid && rd_addr == ADDR_SECOND_VALUE |-> rb <= 8'h59 && rb[3:0] <= 4'h9)
        else $error("second out of range");
    a_minute_bcd: assert property (s_axi_rvalid && rd_addr == ADDR_MINUTE_VALUE |-> rb <= 8'h59 && rb[3:0] <= 4'h9)
        else $error("minute out of range");
    a_hour_bcd: assert property (s_axi_rvalid && rd_addr == ADDR_HOUR_VALUE |-> rb <= 8'h23 && rb[3:0] <= 4'h9)
        else $error("hour out of range");
    a_weekday_range: assert property (s_axi_rvalid && rd_addr == ADDR_WEEKDAY_VALUE |-> rb <= 8'h06)
        else $error("weekday out of range");
    a_day_bcd: assert property (s_axi_rvalid && rd_addr == ADDR_DAY_OF_MONTH_VALUE |-> rb <= 8'h31 && rb[3:0] <= 4'h9)
        else $error("day out of range");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
    c_irq: cover property ($rose(irq));
endmodule

bind ccu_calendar_clock_unit ccu_monitor u_mon (.clk_sys(clk_sys), .resetn(resetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));

// file: ccu_pkg.sv
// Package for the calendar clock unit: register map, field layout, constants.
// Assumes a 125 MHz system clock and a 32.768 kHz crystal clock input sampled as a pin.
package ccu_pkg;

    // ****************************************************************
    // Register byte addresses
    // ****************************************************************
    localparam logic [7:0] ADDR_SECOND_VALUE = 8'h00;
    localparam logic [7:0] ADDR_MINUTE_VALUE = 8'h04;
    localparam logic [7:0] ADDR_HOUR_VALUE = 8'h08;
    localparam logic [7:0] ADDR_WEEKDAY_VALUE = 8'h0C;
    localparam logic [7:0] ADDR_DAY_OF_MONTH_VALUE = 8'h10;
    localparam logic [7:0] ADDR_MONTH_VALUE = 8'h14;
    localparam logic [7:0] ADDR_YEAR_VALUE = 8'h18;
    localparam logic [7:0] ADDR_CONTROL = 8'h1C;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h24;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;
    localparam logic [7:0] ADDR_CALIBRATION = 8'h2C;

    // ****************************************************************
    // Control register fields
    // ****************************************************************
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_UNLOCK_BIT = 1;
    localparam int CTRL_OUT_EN_BIT = 2;
    localparam int CTRL_OUT_SEL_BIT = 3;
    localparam logic [7:0] CTRL_RESET = 8'h01;

    // Interrupt bits: second tick, half-second tick, minute rollover, hour rollover
    localparam int IRQ_SECOND_BIT = 0;
    localparam int IRQ_HALF_BIT = 1;
    localparam int IRQ_MINUTE_BIT = 2;
    localparam int IRQ_DAY_BIT = 3;
    localparam int IRQ_WIDTH = 4;

    // ****************************************************************
    // Value register field widths and reset values
    // ****************************************************************
    localparam logic [7:0] SECOND_MASK = 8'h7F;
    localparam logic [7:0] MINUTE_MASK = 8'h7F;
    localparam logic [7:0] HOUR_MASK = 8'h3F;
    localparam logic [7:0] WEEKDAY_MASK = 8'h07;
    localparam logic [7:0] DAY_MASK = 8'h3F;
    localparam logic [7:0] MONTH_MASK = 8'h1F;
    localparam logic [7:0] DAY_RESET = 8'h01;
    localparam logic [7:0] MONTH_RESET = 8'h01;
    localparam logic [7:0] ZERO_RESET = 8'h00;

    // Crystal half period count and calibration
    localparam int XTAL_HZ = 32768;
    localparam int HALF_SECOND_TICKS = XTAL_HZ / 2;
    localparam int CAL_INTERVAL_SECONDS = 60;
    localparam int SYS_CLK_MHZ = 125;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic [7:0] second;
        logic [7:0] minute;
        logic [7:0] hour;
        logic [7:0] weekday;
        logic [7:0] day;
        logic [7:0] month;
        logic [7:0] year;
    } ccu_time_t;

    typedef enum logic [1:0] {
        CCU_W_IDLE = 2'b00,
        CCU_W_RESP = 2'b01
    } ccu_wstate_t;

endpackage

// file: tb_top.sv
// Testbench for the calendar clock unit: bus master, time model, rollover and lock tests.
// Assumes HALF_TICKS of 4 and a crystal level toggled every 4 system cycles.
`timescale 1ns/100ps
module tb_top;
    import ccu_pkg::*;
    logic clk_sys = 0, resetn = 0, xtal_clk = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0;
    logic [3:0] wstrb = 0;
    wire awready, wready, bvalid, arready, rvalid, irq, clk_out;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    int bad_count = 0, check_count = 0, cyc = 0, np = 0, na = 0, tm[7];
    logic [15:0] lf = 16'hEE9C;
    logic [7:0] adr[7] = '{ADDR_SECOND_VALUE, ADDR_MINUTE_VALUE, ADDR_HOUR_VALUE, ADDR_WEEKDAY_VALUE,
        ADDR_DAY_OF_MONTH_VALUE, ADDR_MONTH_VALUE, ADDR_YEAR_VALUE};
    logic [7:0] raw[5] = '{8'hD9, 8'hA7, 8'hC5, 8'hFD, 8'hD1};
    logic [7:0] msk[5] = '{SECOND_MASK, MINUTE_MASK, HOUR_MASK, WEEKDAY_MASK, DAY_MASK};
    int cs[3][7] = '{'{59, 59, 23, 6, 28, 2, 0}, '{59, 59, 23, 3, 28, 2, 1}, '{59, 59, 23, 5, 31, 12, 99}};
    ccu_calendar_clock_unit #(.HALF_TICKS(4)) u_dut (.clk_sys(clk_sys), .resetn(resetn), .xtal_clk(xtal_clk),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irq(irq), .clock_out_pin(clk_out));
    initial forever #4 clk_sys = ~clk_sys;
    // ****************************************************************
    // Crystal level and run limit
    // ****************************************************************
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        xtal_clk <= cyc[2];
        if (clk_out === 1'b1) np <= np + 1;
        if (cyc == 30000) begin
            bad_count++;
            test_done;
        end
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmp_data(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: data %h expected %h", $time, g, e);
        end
    endtask
    task automatic cmp_resp(input logic [1:0] g, input logic [1:0] e);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: response %b expected %b", $time, g, e);
        end
    endtask
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic logic [7:0] bcd(input int v);
        return 8'((v / 10) * 16 + v % 10);
    endfunction
    function automatic int dim(input int mo, input int yr);
        if (mo == 2) return (yr % 4 == 0) ? 29 : 28;
        if (mo == 4 || mo == 6 || mo == 9 || mo == 11) return 30;
        return 31;
    endfunction
    // ****************************************************************
    // Bus master
    // ****************************************************************
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n = 0;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (n == 0) begin
            @(posedge clk_sys);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                r = bresp;
                n = 1;
            end
        end
        bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n = 0;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (n == 0) begin
            @(posedge clk_sys);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                d = rdata;
                r = rresp;
                n = 1;
            end
        end
        rready <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_write(a, d, r);
        cmp_resp(r, RESP_OKAY);
    endtask
    task automatic rd_cmp(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        cmp_data(d, {24'h00_0000, e});
        cmp_resp(r, RESP_OKAY);
    endtask
    task automatic wait_irq;
        int n;
        for (n = 0; n < 300 && irq !== 1'b1; n++) @(posedge clk_sys);
    endtask
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (8) @(posedge clk_sys);
        resetn <= 1'b1;
        wr(ADDR_CONTROL, 32'h0000_0002);
        for (int i = 0; i < 5; i++) begin
            wr(adr[i], {24'hFF_FFFF, raw[i]});
            rd_cmp(adr[i], raw[i] & msk[i]);
        end
        $display("test upper bits done");
        tm = '{30, 10, 12, 4, 15, 6, 24};
        for (int i = 0; i < 7; i++) wr(adr[i], bcd(tm[i]));
        wr(ADDR_CONTROL, 32'h0000_0000);
        wr(ADDR_HOUR_VALUE, 32'h0000_0007);
        wr(ADDR_WEEKDAY_VALUE, 32'h0000_0002);
        wr(ADDR_DAY_OF_MONTH_VALUE, 32'h0000_0003);
        wr(ADDR_MINUTE_VALUE, 32'h0000_0044);
        tm[1] = 44;
        for (int i = 0; i < 5; i++) rd_cmp(adr[i], bcd(tm[i]));
        $display("test write lock done");
        wr(ADDR_STATUS, '0);
        for (int k = 0; k < 5; k++) begin
            if (k < 3) tm = cs[k];
            else tm = '{int'(lf) % 60, int'(lf >> 4) % 60, int'(lf >> 8) % 24, int'(lf) % 7, 1 + int'(lf) % 28, 1 + int'(lf) % 12, int'(lf) % 100};
            lf = lfsr(lfsr(lf));
            wr(ADDR_CONTROL, 32'h0000_0002);
            for (int i = 0; i < 7; i++) wr(adr[i], bcd(tm[i]));
            axi_read(ADDR_IRQ_STATUS, d, r);
            wr(ADDR_IRQ_MASK, 32'h0000_0001);
            wr(ADDR_CONTROL, 32'h0000_0007);
            wait_irq;
            cmp_data({31'h0, irq}, 32'h0000_0001);
            wr(ADDR_CONTROL, 32'h0000_0002);
            tm[0]++;
            if (tm[0] == 60) begin
                tm[0] = 0;
                na++;
                tm[1]++;
                if (tm[1] == 60) begin
                    tm[1] = 0;
                    tm[2]++;
                    if (tm[2] == 24) begin
                        tm[2] = 0;
                        tm[3] = (tm[3] + 1) % 7;
                        tm[4]++;
                        if (tm[4] > dim(tm[5], tm[6])) begin
                            tm[4] = 1;
                            tm[5]++;
                            if (tm[5] == 13) begin
                                tm[5] = 1;
                                tm[6] = (tm[6] + 1) % 100;
                            end
                        end
                    end
                end
            end
            for (int i = 0; i < 7; i++) rd_cmp(adr[i], bcd(tm[i]));
        end
        cmp_data(np, na);
        $display("test rollover done");
        wr(ADDR_IRQ_MASK, 32'h0000_0000);
        wr(ADDR_CONTROL, 32'h0000_0003);
        repeat (80) @(posedge clk_sys);
        cmp_data({31'h0, irq}, 32'h0000_0000);
        wr(ADDR_IRQ_MASK, 32'h0000_0002);
        wait_irq;
        cmp_data({31'h0, irq}, 32'h0000_0001);
        wr(ADDR_CONTROL, 32'h0000_0002);
        axi_read(ADDR_IRQ_STATUS, d, r);
        cmp_data(d & 32'h0000_0003, 32'h0000_0003);
        repeat (3) @(posedge clk_sys);
        cmp_data({31'h0, irq}, 32'h0000_0000);
        $display("test interrupt done");
        axi_read(8'h30, d, r);
        cmp_resp(r, RESP_SLVERR);
        cmp_data(d, 32'h0000_0000);
        axi_write(8'h30, 32'h0000_0001, r);
        cmp_resp(r, RESP_SLVERR);
        $display("test unmapped done");
        test_done;
    end
endmodule
